/* testbench/pnc_int_source.sv */
`timescale 1ns/100ps
module pnc_int_source (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] req,
    output logic int1Pin,
    output logic otherIntHigh,
    output logic otherIntLow,
    output logic globalIntEnable
);
    // Levels move just after an edge, so the design never samples them mid-change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {int1Pin, otherIntHigh, otherIntLow, globalIntEnable} <= 4'h0;
        end else begin
            {int1Pin, otherIntHigh, otherIntLow, globalIntEnable} <= req;
        end
    end
endmodule

/* testbench/pnc_privilege_nmi_config_checker.sv */
`timescale 1ns/100ps
module pnc_privilege_nmi_config_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic int1Pin,
    input wire logic globalIntEnable,
    input wire pnc_pkg::pnc_intreq_s intReq,
    input wire logic [1:0] serviceSource,
    input wire logic privilegeActive,
    input wire logic [7:0] protCfg
);
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Reads take one wait state, writes none
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_okay_resp: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    // Lock never falls back without reset
    a_priv_sticky: assert property (!privilegeActive |=> !privilegeActive)
        else $error("privilege mode came back without reset");
    a_prot_frozen: assert property (!privilegeActive |=> $stable(protCfg))
        else $error("protected byte changed while locked");
    // Pin to request is four edges, so the pin must have been high then
    a_nmi_needs_pin: assert property (intReq.nmi |-> $past(int1Pin, 4))
        else $error("nmi request without pin");
    a_nmi_ranks_top: assert property (intReq.nmi |-> serviceSource == 2'h3)
        else $error("nmi request not serviced first");
    a_nmi_unmasked: assert property (intReq.nmi && !globalIntEnable |-> serviceSource == 2'h3)
        else $error("nmi held off by global mask");
endmodule

/* testbench/pnc_privilege_nmi_config_tb.sv */
`timescale 1ns/100ps
module pnc_privilege_nmi_config_tb;
    typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} pnc_row_s;
    logic clk, rstn, hsel, hwrite, hready, hresp, privilegeActive;
    logic int1Pin, otherIntHigh, otherIntLow, globalIntEnable;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, serviceSource;
    logic [3:0] intCmd;
    logic [7:0] protCfg;
    pnc_pkg::pnc_intreq_s intReq;
    int mismatches, checks;
    // Write then read back, unlocked; 8'h10 is unmapped
    pnc_row_s rows [5] = '{'{pnc_pkg::PROTCFG_OFS, 8'h5a, 8'h5a}, '{pnc_pkg::INT1CTL_OFS, 8'h03, 8'h03},
        '{8'h10, 8'hff, 8'h00}, '{pnc_pkg::SYSCFG2_OFS, 8'h02, 8'h02}, '{pnc_pkg::SYSCFG2_OFS, 8'h00, 8'h00}};

    pnc_privilege_nmi_config dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .int1Pin(int1Pin), .globalIntEnable(globalIntEnable),
        .otherIntHigh(otherIntHigh), .otherIntLow(otherIntLow), .intReq(intReq),
        .serviceSource(serviceSource), .privilegeActive(privilegeActive), .protCfg(protCfg));
    pnc_int_source src (.clk(clk), .rstn(rstn), .req(intCmd), .int1Pin(int1Pin),
        .otherIntHigh(otherIntHigh), .otherIntLow(otherIntLow), .globalIntEnable(globalIntEnable));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait; a hung slave ends the run
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] w, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= pnc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        waitReady();
        htrans <= 2'h0;
        hwdata <= {24'h000000, w};
        waitReady();
        r = hrdata;
    endtask

    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 8'h00, rd);
        chk(name, e, rd);
    endtask

    // Pin, other high, other low, global enable; eight edges covers the four-edge path
    task automatic setInt(input logic [3:0] c);
        @(posedge clk);
        intCmd <= c;
        repeat (8) @(posedge clk);
    endtask

    task automatic doReset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rstn, hsel, hwrite, haddr, hwdata, htrans, intCmd} = '0;
        mismatches = 0;
        checks = 0;
        doReset();
        chk("privilegeActive", 32'h1, {31'h0, privilegeActive});
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].w, rd);
            rdChk("row", rows[i].a, {24'h000000, rows[i].e});
        end
        // Maskable: enabled at high priority, then masked
        setInt(4'b1001);
        chk("intReq", 32'h2, {29'h0, intReq});
        chk("serviceSource", 32'h2, {30'h0, serviceSource});
        setInt(4'b1000);
        chk("serviceSource", 32'h0, {30'h0, serviceSource});
        // Nonmaskable while disabled and masked, beside a high source the same mask holds off
        bus(pnc_pkg::SYSCFG2_OFS, 1'b1, 8'h02, rd);
        bus(pnc_pkg::INT1CTL_OFS, 1'b1, 8'h00, rd);
        setInt(4'b1100);
        chk("nmi", 32'h1, {31'h0, intReq.nmi});
        chk("serviceSource", 32'h3, {30'h0, serviceSource});
        // Lock with nmi kept, then try to undo both and rewrite the byte
        bus(pnc_pkg::SYSCFG2_OFS, 1'b1, 8'h03, rd);
        rdChk("lock", pnc_pkg::SYSCFG2_OFS, 32'h3);
        chk("privilegeActive", 32'h0, {31'h0, privilegeActive});
        bus(pnc_pkg::SYSCFG2_OFS, 1'b1, 8'h00, rd);
        rdChk("lock", pnc_pkg::SYSCFG2_OFS, 32'h3);
        bus(pnc_pkg::PROTCFG_OFS, 1'b1, 8'ha5, rd);
        rdChk("protCfg", pnc_pkg::PROTCFG_OFS, 32'h5a);
        chk("protCfg", 32'h5a, {24'h0, protCfg});
        rdChk("status", pnc_pkg::STATUS_OFS, 32'h7);
        // Writing 1 clears the sticky reject flag; pin, nmi and lock state stay
        bus(pnc_pkg::STATUS_OFS, 1'b1, 8'h01, rd);
        rdChk("status", pnc_pkg::STATUS_OFS, 32'h6);
        setInt(4'b1000);
        chk("nmi", 32'h1, {31'h0, intReq.nmi});
        // Only reset unlocks
        doReset();
        rdChk("lock", pnc_pkg::SYSCFG2_OFS, 32'h0);
        chk("privilegeActive", 32'h1, {31'h0, privilegeActive});
        rdChk("protCfg", pnc_pkg::PROTCFG_OFS, 32'h0);
        // Maskable at low priority beside another low source, then another high source alone
        bus(pnc_pkg::INT1CTL_OFS, 1'b1, 8'h01, rd);
        setInt(4'b1011);
        chk("intReq", 32'h1, {29'h0, intReq});
        chk("serviceSource", 32'h1, {30'h0, serviceSource});
        setInt(4'b0101);
        chk("intReq", 32'h2, {29'h0, intReq});
        chk("serviceSource", 32'h2, {30'h0, serviceSource});
        tally_and_finish();
    end
endmodule

bind pnc_privilege_nmi_config pnc_privilege_nmi_config_checker u_chk (.clk(clk), .rstn(rstn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .int1Pin(int1Pin), .globalIntEnable(globalIntEnable), .intReq(intReq),
    .serviceSource(serviceSource), .privilegeActive(privilegeActive), .protCfg(protCfg));

/* verilog/pnc_int1_arbiter.sv */
`timescale 1ns/100ps
module pnc_int1_arbiter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic int1Level,
    input wire logic nmiMode,
    input wire logic int1Enable,
    input wire logic int1PrioHigh,
    input wire logic globalIntEnable,
    output pnc_pkg::pnc_intreq_s intReq
);

    pnc_pkg::pnc_intreq_s nxt_intReq;

    // ----------------------------------------
    // Routing of interrupt 1
    // ----------------------------------------
    // Nonmaskable path bypasses enable, priority select and global mask
    always_comb begin
        nxt_intReq.nmi = int1Level & nmiMode; // [R4] [R5] [R6] [R7]
        nxt_intReq.high = int1Level & ~nmiMode & int1Enable & int1PrioHigh & globalIntEnable; // [R4]
        nxt_intReq.low = int1Level & ~nmiMode & int1Enable & ~int1PrioHigh & globalIntEnable; // [R4]
    end

    // Registered so the request lines never glitch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intReq <= '0;
        end else begin
            intReq <= nxt_intReq;
        end
    end

endmodule

/* verilog/pnc_pkg.sv */
package pnc_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] SYSCFG2_OFS = 8'h00;
    localparam logic [7:0] PROTCFG_OFS = 8'h04;
    localparam logic [7:0] INT1CTL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int LOCK_BIT = 0;
    localparam int NMISEL_BIT = 1;
    localparam int INT1_EN_BIT = 0;
    localparam int INT1_PRIO_BIT = 1;
    localparam int ST_REJECT_BIT = 0;
    localparam int ST_PIN_BIT = 1;
    localparam int ST_NMI_BIT = 2;
    localparam int ST_PRIV_BIT = 3;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic LOCK_RST = 1'b0;
    localparam logic NMISEL_RST = 1'b0;
    localparam logic [7:0] PROTCFG_RST = 8'h00;
    localparam logic INT1_EN_RST = 1'b0;
    localparam logic INT1_PRIO_RST = 1'b0;

    // ----------------------------------------
    // Bus encodings and synchroniser depth
    // ----------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic HRESP_OKAY = 1'b0;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic nmi;
        logic high;
        logic low;
    } pnc_intreq_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] ofs;
    } pnc_busreq_s;

endpackage

/* verilog/pnc_privilege_nmi_config.sv */
`timescale 1ns/100ps
// What this block does
// [R1] Writing 1 to the lock bit leaves privilege mode and blocks later writes to protected bits.
// [R2] The lock bit clears only on reset; writing 0 to it does nothing.
// [R3] Protected configuration bits change only while privilege mode is active.
// [R4] The nonmaskable-select bit makes interrupt 1 maskable when 0 and nonmaskable when 1.
// [R5] A nonmaskable interrupt 1 ranks just below reset, above every other source.
// [R6] A nonmaskable interrupt 1 is neither blocked nor delayed by the global interrupt mask.
// [R7] In nonmaskable mode the enable and priority-select bits of interrupt 1 are ignored.
// [R8] The nonmaskable-select bit can be written only while privilege mode is active.
// [R9] The lock bit reads 0 in privilege mode and 1 once privilege mode is disabled.
module pnc_privilege_nmi_config #(
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt side
    input wire logic int1Pin,
    input wire logic globalIntEnable,
    input wire logic otherIntHigh,
    input wire logic otherIntLow,
    output pnc_pkg::pnc_intreq_s intReq,
    output logic [1:0] serviceSource,
    // Configuration outputs
    output logic privilegeActive,
    output logic [7:0] protCfg
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rstMeta_ff;
    logic rstSyncN_ff;

    // Asserts at once, releases two edges later
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'b0;
            rstSyncN_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSyncN_ff <= rstMeta_ff;
        end
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    pnc_pkg::pnc_busreq_s busReq_ff;
    logic lock_ff;
    logic nmiSel_ff;
    logic [7:0] protCfg_ff;
    logic int1En_ff;
    logic int1Prio_ff;
    logic reject_ff;
    logic int1Sync;
    logic accept;
    logic wrPhase;
    logic [7:0] wrByte;
    logic privWrAttempt;
    logic rejectEvent;
    logic rejectClear;
    logic [7:0] rdByte;
    pnc_pkg::pnc_intreq_s int1Req;
    logic [1:0] nxt_serviceSource;

    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    // Interrupt pin is asynchronous to clk
    pnc_sync #(
        .WIDTH(1)
    ) u_int1_sync (
        .clk(clk),
        .rstn(rstSyncN_ff),
        .asyncIn(int1Pin),
        .syncOut(int1Sync)
    );

    // ----------------------------------------
    // Bus address phase
    // ----------------------------------------
    // Only NONSEQ is used by the master; SEQ is treated alike
    assign accept = hsel & htrans[1] & hready;

    // Capture address phase; hsize is ignored, only words are used
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            busReq_ff <= '0;
        end else if (hready) begin
            busReq_ff.valid <= accept;
            busReq_ff.write <= hwrite;
            busReq_ff.ofs <= haddr[7:0];
        end
    end

    // Reads take one wait state so that a write just ahead is seen
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= ~(accept & ~hwrite);
        end
    end

    // Response is always OKAY
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            hresp <= pnc_pkg::HRESP_OKAY;
        end else begin
            hresp <= pnc_pkg::HRESP_OKAY;
        end
    end

    // ----------------------------------------
    // Write data phase
    // ----------------------------------------
    assign wrPhase = busReq_ff.valid & busReq_ff.write;
    assign wrByte = hwdata[7:0];

    // A write to the protected byte, or one that would change the nonmaskable select, once privilege is gone
    assign privWrAttempt = wrPhase & lock_ff &
        (busReq_ff.ofs == pnc_pkg::PROTCFG_OFS ||
        (busReq_ff.ofs == pnc_pkg::SYSCFG2_OFS && wrByte[pnc_pkg::NMISEL_BIT] != nmiSel_ff));
    assign rejectEvent = privWrAttempt;
    assign rejectClear = wrPhase & (busReq_ff.ofs == pnc_pkg::STATUS_OFS) & wrByte[pnc_pkg::ST_REJECT_BIT];

    // ----------------------------------------
    // Privilege lock bit
    // ----------------------------------------
    // Set only; writing 0 is ignored, reset alone clears it
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            lock_ff <= pnc_pkg::LOCK_RST; // [R2]
        end else if (wrPhase && busReq_ff.ofs == pnc_pkg::SYSCFG2_OFS && wrByte[pnc_pkg::LOCK_BIT]) begin
            lock_ff <= 1'b1; // [R1]
        end
    end

    // ----------------------------------------
    // Interrupt 1 nonmaskable select
    // ----------------------------------------
    // A write carrying the lock bit may still set this bit in the same cycle
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            nmiSel_ff <= pnc_pkg::NMISEL_RST;
        end else if (wrPhase && busReq_ff.ofs == pnc_pkg::SYSCFG2_OFS && !lock_ff) begin
            nmiSel_ff <= wrByte[pnc_pkg::NMISEL_BIT]; // [R8] [R4]
        end
    end

    // ----------------------------------------
    // Protected configuration byte
    // ----------------------------------------
    // Stands for the other privilege-write fields of the chip
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            protCfg_ff <= pnc_pkg::PROTCFG_RST;
        end else if (wrPhase && busReq_ff.ofs == pnc_pkg::PROTCFG_OFS && !lock_ff) begin
            protCfg_ff <= wrByte; // [R3] [R1]
        end
    end

    // ----------------------------------------
    // Interrupt 1 control
    // ----------------------------------------
    // Always writable; ignored downstream in nonmaskable mode
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            int1En_ff <= pnc_pkg::INT1_EN_RST;
            int1Prio_ff <= pnc_pkg::INT1_PRIO_RST;
        end else if (wrPhase && busReq_ff.ofs == pnc_pkg::INT1CTL_OFS) begin
            int1En_ff <= wrByte[pnc_pkg::INT1_EN_BIT];
            int1Prio_ff <= wrByte[pnc_pkg::INT1_PRIO_BIT];
        end
    end

    // ----------------------------------------
    // Rejected-write flag
    // ----------------------------------------
    // Sticky; a new rejection in the clearing cycle wins
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            reject_ff <= 1'b0;
        end else if (rejectEvent) begin
            reject_ff <= 1'b1; // [R1]
        end else if (rejectClear) begin
            reject_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        rdByte = 8'h00;
        if (busReq_ff.ofs == pnc_pkg::SYSCFG2_OFS) begin
            rdByte[pnc_pkg::LOCK_BIT] = lock_ff; // [R9]
            rdByte[pnc_pkg::NMISEL_BIT] = nmiSel_ff;
        end else if (busReq_ff.ofs == pnc_pkg::PROTCFG_OFS) begin
            rdByte = protCfg_ff;
        end else if (busReq_ff.ofs == pnc_pkg::INT1CTL_OFS) begin
            rdByte[pnc_pkg::INT1_EN_BIT] = int1En_ff;
            rdByte[pnc_pkg::INT1_PRIO_BIT] = int1Prio_ff;
        end else if (busReq_ff.ofs == pnc_pkg::STATUS_OFS) begin
            rdByte[pnc_pkg::ST_REJECT_BIT] = reject_ff;
            rdByte[pnc_pkg::ST_PIN_BIT] = int1Sync;
            rdByte[pnc_pkg::ST_NMI_BIT] = nmiSel_ff;
            rdByte[pnc_pkg::ST_PRIV_BIT] = ~lock_ff;
        end
    end

    // Loaded in the wait cycle, stands until the next read
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            hrdata <= 32'h0000_0000;
        end else if (busReq_ff.valid && !busReq_ff.write && !hreadyout) begin
            hrdata <= {24'h00_0000, rdByte};
        end
    end

    // ----------------------------------------
    // Interrupt 1 routing
    // ----------------------------------------
    pnc_int1_arbiter u_arbiter (
        .clk(clk),
        .rstn(rstSyncN_ff),
        .int1Level(int1Sync),
        .nmiMode(nmiSel_ff),
        .int1Enable(int1En_ff),
        .int1PrioHigh(int1Prio_ff),
        .globalIntEnable(globalIntEnable),
        .intReq(int1Req)
    );

    // ----------------------------------------
    // Service ranking
    // ----------------------------------------
    // 3 = int1_nonmask_select, 2 = high level, 1 = low level, 0 = none
    always_comb begin
        if (int1Req.nmi) begin
            nxt_serviceSource = 2'h3; // [R5] [R6]
        end else if (int1Req.high || (otherIntHigh && globalIntEnable)) begin
            nxt_serviceSource = 2'h2;
        end else if (int1Req.low || (otherIntLow && globalIntEnable)) begin
            nxt_serviceSource = 2'h1;
        end else begin
            nxt_serviceSource = 2'h0;
        end
    end

    // Request lines and ranking, all from flops
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            intReq <= '0;
            serviceSource <= 2'h0;
        end else begin
            intReq.nmi <= int1Req.nmi; // [R7]
            intReq.high <= int1Req.high | (otherIntHigh & globalIntEnable);
            intReq.low <= int1Req.low | (otherIntLow & globalIntEnable);
            serviceSource <= nxt_serviceSource;
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstSyncN_ff) begin
        if (!rstSyncN_ff) begin
            privilegeActive <= 1'b1;
            protCfg <= pnc_pkg::PROTCFG_RST;
        end else begin
            privilegeActive <= ~lock_ff; // [R1]
            protCfg <= protCfg_ff;
        end
    end

endmodule

/* verilog/pnc_sync.sv */
`timescale 1ns/100ps
module pnc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;

    // Two flops; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_ff <= '0;
            syncOut <= '0;
        end else begin
            stage1_ff <= asyncIn;
            syncOut <= stage1_ff;
        end
    end

endmodule
